// ### design/agc_cfg_regs.sv
// group c correction, lane pattern and high-pass configuration registers
// assumes a plain strobe register port on ref_clk and rising-edge logic
//
// Overview of operation
// R1 - channel 12 even samples get a gain of n times 0.2 db from bits 15-11; ch12_even_gain_cdb is kept to 8 bits and wraps for n above 12.
// R2 - that gain field is used only while the global gain enable is one.
// R3 - with global offset enable set, bits 9-0 are subtracted from samples.
// R4 - the offset is two's complement with a 14-bit lsb weight.
// R5 - lanes 9 to 12 each have a prbs enable at bits 15 to 12.
// R6 - the lane prbs and pattern fields act only while per-lane select is one.
// R7 - lane 9 pattern sits at bits 11-9 and lane 10 at bits 8-6.
// R8 - software programs the corner k in bits 4-1 only with 2 through 10.
// R9 - the corner k shapes the high-pass only while the filter is enabled.
// R10 - bit 0 enables the group high-pass filter, reset value zero.
// R11 - after reset every field of both registers reads zero.
// R12 - software writes zero to the reserved bits 10 and 5.
//
// Local design decision: strobed register access.
`include "agc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module agc_cfg_regs #(
   parameter int ADDR_W = 8
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // global enables held in other registers
   input wire logic global_gain_enable,
   input wire logic global_offset_enable,
   input wire logic per_lane_pattern_select,
   // channel 12 even correction
   output logic [4:0] ch12_even_gain,
   output logic [7:0] ch12_even_gain_cdb,
   output logic signed [13:0] ch12_even_offset,
   // lane test sources, index 0 is lane 9
   output logic [3:0] lane_prbs_on,
   output logic [2:0] lane9_pattern_code,
   output logic [2:0] lane10_pattern_code,
   // group high-pass
   output logic group_c_highpass_enable,
   output logic [3:0] group_c_highpass_k,
   output logic highpass_k_bad
);
   typedef struct packed {
      agc_pkg::agc_word_t gain_ofs;
      agc_pkg::agc_word_t pat_hpf;
      agc_pkg::agc_word_t rdata;
   } agc_state_t;

   agc_state_t st_r;
   agc_state_t st_nxt;

   // reserved bits are stored as written, software keeps them zero
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] off);
      addr_hit = (a == ADDR_W'(off));
   endfunction

   // register writes and one-cycle-later read data
   always_comb begin
      st_nxt = st_r;
      if (reg_wr && addr_hit(reg_addr, `AGC_ADDR_GAIN_OFS)) begin
         st_nxt.gain_ofs = reg_wdata; // [R12]
      end
      if (reg_wr && addr_hit(reg_addr, `AGC_ADDR_PAT_HPF)) begin
         st_nxt.pat_hpf = reg_wdata;
      end
      st_nxt.rdata = 16'h0000; // unmapped and idle cycles read zero
      if (reg_rd) begin
         if (addr_hit(reg_addr, `AGC_ADDR_GAIN_OFS)) begin
            st_nxt.rdata = st_r.gain_ofs;
         end else if (addr_hit(reg_addr, `AGC_ADDR_PAT_HPF)) begin
            st_nxt.rdata = st_r.pat_hpf;
         end
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= '{`AGC_RST_GAIN_OFS, `AGC_RST_PAT_HPF, 16'h0000}; // [R11]
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;

   agc_even_corr u_corr (
      .gain_en(global_gain_enable),
      .ofs_en(global_offset_enable),
      .gain_code(st_r.gain_ofs[`AGC_GAIN_MSB:`AGC_GAIN_LSB]),
      .ofs_code(st_r.gain_ofs[`AGC_OFS_MSB:`AGC_OFS_LSB]),
      .gain_eff(ch12_even_gain),
      .gain_cdb(ch12_even_gain_cdb),
      .ofs_eff(ch12_even_offset)
   );

   // prbs bit 15 is lane 9, bit 12 is lane 12
   logic [2:0] pat_on [4];
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         logic [2:0] code;
         assign code = (gi == 0) ?
            st_r.pat_hpf[`AGC_PAT9_MSB:`AGC_PAT9_LSB] :
            (gi == 1) ? st_r.pat_hpf[`AGC_PAT10_MSB:`AGC_PAT10_LSB] : 3'h0;
         agc_lane_sel u_sel (
            .pat_sel(per_lane_pattern_select),
            .prbs_en(st_r.pat_hpf[`AGC_PRBS_MSB - gi]), // [R5]
            .pat_code(code),
            .prbs_on(lane_prbs_on[gi]),
            .pat_on(pat_on[gi])
         );
      end
   endgenerate
   assign lane9_pattern_code = pat_on[0]; // [R7]
   assign lane10_pattern_code = pat_on[1];

   // k reaches the filter only while it is enabled
   assign group_c_highpass_enable = st_r.pat_hpf[`AGC_HPEN_BIT]; // [R10]
   assign group_c_highpass_k = group_c_highpass_enable ?
      st_r.pat_hpf[`AGC_HPK_MSB:`AGC_HPK_LSB] : 4'h0; // [R9]
   // flags a corner code outside the range software must keep to
   assign highpass_k_bad = group_c_highpass_enable &&
      ((group_c_highpass_k < `AGC_HPK_MIN) ||
       (group_c_highpass_k > `AGC_HPK_MAX)); // [R8]

   // assertions
   chk_wr_gain_stores: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en && reg_wr && reg_addr == ADDR_W'(`AGC_ADDR_GAIN_OFS)
      |=> st_r.gain_ofs == $past(reg_wdata)) // [R11]
      else $error("gain offset write not stored");
   // checks reads of the pattern register only: the bench reads both addresses many times
   chk_rd_one_later: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en && reg_rd && reg_addr == ADDR_W'(`AGC_ADDR_PAT_HPF) && !reg_wr
      |=> reg_rdata == $past(st_r.pat_hpf)) // [R10]
      else $error("read data wrong");
   chk_lane9_map: assert property (@(posedge ref_clk) disable iff (rst)
      per_lane_pattern_select |-> lane9_pattern_code == st_r.pat_hpf[11:9]) // [R7]
      else $error("lane 9 pattern wrong");
   chk_hpen_map: assert property (@(posedge ref_clk) disable iff (rst)
      group_c_highpass_enable == st_r.pat_hpf[0]) // [R10]
      else $error("highpass enable not bit zero");
   chk_gain_gate: assert property (@(posedge ref_clk) disable iff (rst)
      !global_gain_enable |-> ch12_even_gain == 5'h00) // [R2]
      else $error("gain applied while disabled");
   chk_gain_scale: assert property (@(posedge ref_clk) disable iff (rst)
      global_gain_enable |-> ch12_even_gain_cdb ==
      8'(st_r.gain_ofs[15:11] * 8'h14)) // [R1]
      else $error("gain step wrong");
   chk_offset_sign: assert property (@(posedge ref_clk) disable iff (rst)
      global_offset_enable |-> ch12_even_offset[13:9] ==
      {5{st_r.gain_ofs[9]}}) // [R4]
      else $error("offset not sign extended");
   chk_offset_gate: assert property (@(posedge ref_clk) disable iff (rst)
      !global_offset_enable |-> ch12_even_offset == 14'h0000) // [R3]
      else $error("offset applied while disabled");
   chk_lane_gate: assert property (@(posedge ref_clk) disable iff (rst)
      !per_lane_pattern_select |-> lane_prbs_on == 4'h0 &&
      lane9_pattern_code == 3'h0) // [R6]
      else $error("lane field active without select");
   chk_prbs_map: assert property (@(posedge ref_clk) disable iff (rst)
      per_lane_pattern_select |-> lane_prbs_on ==
      {st_r.pat_hpf[12], st_r.pat_hpf[13], st_r.pat_hpf[14],
       st_r.pat_hpf[15]}) // [R5]
      else $error("prbs lane mapping wrong");
   chk_pat10_map: assert property (@(posedge ref_clk) disable iff (rst)
      per_lane_pattern_select |-> lane10_pattern_code == st_r.pat_hpf[8:6]) // [R7]
      else $error("lane 10 pattern wrong");
   chk_hpf_gate: assert property (@(posedge ref_clk) disable iff (rst)
      !st_r.pat_hpf[0] |-> group_c_highpass_k == 4'h0 &&
      !highpass_k_bad) // [R9]
      else $error("corner used while filter off");
   chk_reset_zero: assert property (@(posedge ref_clk)
      $fell(rst) |-> st_r.gain_ofs == 16'h0000 && st_r.pat_hpf == 16'h0000) // [R11]
      else $error("registers not zero after reset");
   chk_freeze: assert property (@(posedge ref_clk) disable iff (rst)
      !clk_en |=> $stable(st_r))
      else $error("state moved while clock enable low");

   cov_gain_on: cover property (@(posedge ref_clk) disable iff (rst)
      global_gain_enable && ch12_even_gain != 5'h00);
   cov_prbs_lane: cover property (@(posedge ref_clk) disable iff (rst)
      lane_prbs_on[3]);
   cov_hpf_on: cover property (@(posedge ref_clk) disable iff (rst)
      group_c_highpass_enable && !highpass_k_bad);
   cov_neg_offset: cover property (@(posedge ref_clk) disable iff (rst)
      global_offset_enable && ch12_even_offset < 0);
endmodule
`default_nettype wire

// ### design/agc_defines.svh
// register offsets, field positions and reset values of the group c
// correction and pattern configuration registers
// assumes inclusion by bare name from design files
`ifndef AGC_DEFINES_SVH
`define AGC_DEFINES_SVH

`define AGC_ADDR_GAIN_OFS 8'h2c
`define AGC_ADDR_PAT_HPF 8'h2d
`define AGC_RST_GAIN_OFS 16'h0000
`define AGC_RST_PAT_HPF 16'h0000

// gain and offset register fields
`define AGC_GAIN_MSB 15
`define AGC_GAIN_LSB 11
`define AGC_OFS_MSB 9
`define AGC_OFS_LSB 0

// pattern and filter register fields
`define AGC_PRBS_MSB 15
`define AGC_PRBS_LSB 12
`define AGC_PAT9_MSB 11
`define AGC_PAT9_LSB 9
`define AGC_PAT10_MSB 8
`define AGC_PAT10_LSB 6
`define AGC_HPK_MSB 4
`define AGC_HPK_LSB 1
`define AGC_HPEN_BIT 0

// valid corner range for k
`define AGC_HPK_MIN 4'h2
`define AGC_HPK_MAX 4'ha

// gain step in hundredths of a db
`define AGC_GAIN_STEP_CDB 8'h14

`endif

// ### design/agc_pkg.sv
// types shared by the group c correction configuration block
// assumes agc_defines.svh supplies the numeric constants
package agc_pkg;
   typedef logic [15:0] agc_word_t;
   typedef logic [4:0] agc_gain_t;
   typedef logic signed [9:0] agc_ofs_t;
   typedef logic [2:0] agc_pat_t;
   typedef logic [3:0] agc_hpk_t;
endpackage

// ### design/agc_lane_sel.sv
// per-lane test source selection for output lanes 9 to 12
// assumes register fields come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module agc_lane_sel (
   // controls
   input wire logic pat_sel,
   input wire logic prbs_en,
   input wire logic [2:0] pat_code,
   // selection
   output logic prbs_on,
   output logic [2:0] pat_on
);
   // lane fields only matter while the per-lane select is set
   assign prbs_on = pat_sel & prbs_en; // [R5] [R6]
   assign pat_on = pat_sel ? pat_code : 3'h0; // [R6] [R7]
endmodule
`default_nettype wire

// ### design/agc_even_corr.sv
// effective gain and offset correction of channel 12 even samples
// assumes register fields and enables are on the same clock
`include "agc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module agc_even_corr (
   // controls
   input wire logic gain_en,
   input wire logic ofs_en,
   input wire logic [4:0] gain_code,
   input wire logic [9:0] ofs_code,
   // effective correction
   output logic [4:0] gain_eff,
   output logic [7:0] gain_cdb,
   output logic signed [13:0] ofs_eff
);
   logic [12:0] prod;
   // gain of n times 0.2 db, in hundredths of a db, kept to 8 bits so it wraps for n above 12
   assign gain_eff = gain_en ? gain_code : 5'h00; // [R2]
   assign prod = gain_eff * `AGC_GAIN_STEP_CDB; // [R1]
   assign gain_cdb = prod[7:0];
   // signed offset sign-extended to the 14-bit lsb weight
   assign ofs_eff = ofs_en ? {{4{ofs_code[9]}}, ofs_code} : 14'h0000; // [R3] [R4]
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the group c correction configuration registers
// assumes agc_cfg_regs on one 125 mhz clock with a strobe register port
`timescale 1ns/1ps
`default_nettype none
`include "agc_defines.svh"
module testbench;
   logic ref_clk, rst, clk_en, reg_wr, reg_rd, p_rd, p_en;
   logic global_gain_enable, global_offset_enable, per_lane_pattern_select;
   logic [7:0] reg_addr, a;
   logic [15:0] reg_wdata, reg_rdata, m_go, m_ph, d;
   logic [4:0] ch12_even_gain;
   logic [7:0] ch12_even_gain_cdb;
   logic signed [13:0] ch12_even_offset;
   logic [3:0] lane_prbs_on, group_c_highpass_k;
   logic [2:0] lane9_pattern_code, lane10_pattern_code;
   logic group_c_highpass_enable, highpass_k_bad;
   int err_total, n_tests;
   logic [15:0] exp_q[$];

   agc_cfg_regs #(.ADDR_W(8)) DUT (.ref_clk(ref_clk), .rst(rst),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .global_gain_enable(global_gain_enable),
      .global_offset_enable(global_offset_enable),
      .per_lane_pattern_select(per_lane_pattern_select),
      .ch12_even_gain(ch12_even_gain), .ch12_even_gain_cdb(ch12_even_gain_cdb),
      .ch12_even_offset(ch12_even_offset), .lane_prbs_on(lane_prbs_on),
      .lane9_pattern_code(lane9_pattern_code),
      .lane10_pattern_code(lane10_pattern_code),
      .group_c_highpass_enable(group_c_highpass_enable),
      .group_c_highpass_k(group_c_highpass_k),
      .highpass_k_bad(highpass_k_bad));

   // free-running clock, 8 ns period
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask

   // bus cycles: strobes change only just after a rising edge
   task automatic wr(input logic [7:0] ad, input logic [15:0] dd);
      @(posedge ref_clk);
      reg_addr <= ad;
      reg_wdata <= dd;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad);
      @(posedge ref_clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      // a frozen port takes no read, so nothing is expected back
      if (clk_en === 1'b1) exp_q.push_back(ad == `AGC_ADDR_GAIN_OFS ? m_go :
         ad == `AGC_ADDR_PAT_HPF ? m_ph : 16'h0000);
   endtask

   task automatic idle;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask

   // outputs against the bench's own copy of both registers
   task automatic chk_out;
      logic [4:0] g;
      logic [3:0] k;
      logic s;
      g = global_gain_enable ? m_go[15:11] : 5'h00;
      k = m_ph[0] ? m_ph[4:1] : 4'h0;
      s = per_lane_pattern_select;
      @(negedge ref_clk);
      cmp(16'(ch12_even_gain), 16'(g), "gain code");
      cmp(16'(ch12_even_gain_cdb), 16'(8'(16'(g) * 16'h0014)), "gain step");
      cmp(16'(ch12_even_offset), global_offset_enable ?
         {{6{m_go[9]}}, m_go[9:0]} : 16'h0000, "offset");
      cmp(16'(lane_prbs_on), s ? 16'({m_ph[12], m_ph[13], m_ph[14],
         m_ph[15]}) : 16'h0000, "prbs lanes");
      cmp(16'({lane9_pattern_code, lane10_pattern_code}),
         s ? 16'(m_ph[11:6]) : 16'h0000, "lane patterns");
      cmp(16'({group_c_highpass_enable, group_c_highpass_k, highpass_k_bad}),
         16'({m_ph[0], k, m_ph[0] && (k < `AGC_HPK_MIN || k > `AGC_HPK_MAX)}),
         "highpass");
   endtask

   // read watcher: oldest note against the data of the cycle after a read
   always @(posedge ref_clk) begin
      p_rd <= reg_rd && clk_en;
      p_en <= clk_en;
   end
   always @(negedge ref_clk) begin
      if (p_rd === 1'b1 && exp_q.size() > 0)
         cmp(reg_rdata, exp_q.pop_front(), "read data");
      else if (p_en === 1'b1)
         cmp(reg_rdata, 16'h0000, "idle read data");
   end

   // watchdog, far beyond the fewer than two hundred cycles the run needs
   initial begin
      #50000;
      err_total++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_sim();
   end

   initial begin
      {rst, clk_en, reg_wr, reg_rd} = 4'b1100;
      {global_gain_enable, global_offset_enable} = 2'b11;
      per_lane_pattern_select = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      m_go = 16'h0000;
      m_ph = 16'h0000;
      err_total = 0;
      n_tests = 0;
      void'($urandom(84));
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      // reset contents, all enables high so any stray bit shows
      rd(`AGC_ADDR_GAIN_OFS);
      rd(`AGC_ADDR_PAT_HPF);
      idle();
      chk_out();
      // random fields under randomly drawn enable mixes, back-to-back strobes
      for (int i = 0; i < 24; i++) begin
         global_gain_enable <= 1'($urandom);
         global_offset_enable <= 1'($urandom);
         per_lane_pattern_select <= 1'($urandom);
         d = (i == 0) ? 16'hfbff : 16'($urandom) & 16'hfbff;
         wr(`AGC_ADDR_GAIN_OFS, d);
         m_go = d;
         d = 16'($urandom) & 16'hffdf;
         // corner k stays legal except on every fourth pass
         if (i % 4 != 3) d[4:1] = 4'(2 + $urandom_range(8));
         wr(`AGC_ADDR_PAT_HPF, d);
         m_ph = d;
         rd(`AGC_ADDR_GAIN_OFS);
         rd(`AGC_ADDR_PAT_HPF);
         idle();
         chk_out();
      end
      // unmapped neighbours and a random address leave both registers
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 8'h2b : (i == 1) ? 8'h2e : 8'($urandom);
         if (a == `AGC_ADDR_GAIN_OFS || a == `AGC_ADDR_PAT_HPF) a = 8'h00;
         wr(a, 16'hffff);
         rd(a);
         rd(`AGC_ADDR_GAIN_OFS);
         rd(`AGC_ADDR_PAT_HPF);
         idle();
         chk_out();
      end
      // frozen clock enable swallows strobes
      clk_en <= 1'b0;
      wr(`AGC_ADDR_GAIN_OFS, ~m_go & 16'hfbff);
      rd(`AGC_ADDR_GAIN_OFS);
      idle();
      clk_en <= 1'b1;
      chk_out();
      rd(`AGC_ADDR_GAIN_OFS);
      idle();
      // let the last read data be checked before reset wipes it
      idle();
      // second reset in mid-run clears everything again
      rst <= 1'b1;
      repeat (3) idle();
      rst <= 1'b0;
      m_go = 16'h0000;
      m_ph = 16'h0000;
      rd(`AGC_ADDR_GAIN_OFS);
      rd(`AGC_ADDR_PAT_HPF);
      idle();
      chk_out();
      repeat (2) idle();
      end_sim();
   end
endmodule
`default_nettype wire
